/* File: design/backlight_params.svh */
/*
 * Constants of the backlight driver register bank: offsets, field positions,
 * reset values and timing figures.
 * Assumes a 20 MHz core clock; included by the package and the register bank.
 */
//
// Functional notes
// - reserved and write-only bits read as zero
// - offset zero read-only, low nibble revision code
// - soft reset bit resets all, self-clears
// - chip and three string enables, default on
// - mapping bit selects linear or exponential
// - source field selects register, duty, product orders
// - ramp steps at 0.125 ms doubling to 16 ms
// - pwm sample clock 800k, 4M or 24M; the 24M setting samples every 20 MHz core cycle
// - pwm polarity bit, default active high
// - hysteresis ignores small duty changes, default four
// - pulse filter none, 100, 150, 200 ns
// - frequency shift bit, zero lowers 12 percent
// - 500k or 1M switching, inductor select bit
// - overvoltage threshold field, default 38 V
// - current limit field, default 1500 mA
// - upper auto-frequency threshold against code MSBs
// - lower auto-frequency threshold against code MSBs
// - brightness low register, three bits, default ones
// - brightness high register holds eight MSBs
// - string-short detection enable, default off
// - fault shutdown disable bits, zero forces shutdown
// - fault flag register bit layout
// - re-enable blocked until fault flags read
`ifndef BACKLIGHT_PARAMS_SVH
`define BACKLIGHT_PARAMS_SVH

`define OFS_REVISION      8'h00
`define OFS_SOFT_RESET    8'h01
`define OFS_ENABLE        8'h10
`define OFS_BRIGHT_CFG    8'h11
`define OFS_PWM_CFG       8'h12
`define OFS_BOOST_CFG     8'h13
`define OFS_AF_UPPER      8'h15
`define OFS_AF_LOWER      8'h16
`define OFS_CODE_LOW      8'h18
`define OFS_CODE_HIGH     8'h19
`define OFS_FAULT_CFG     8'h1E
`define OFS_FAULT_STATUS  8'h1F

`define RST_ENABLE        4'hF
`define RST_BRIGHT_CFG    7'h30
`define RST_PWM_CFG       8'hF3
`define RST_BOOST_CFG     7'h6F
`define RST_AF            8'h00
`define RST_CODE_LOW      3'h7
`define RST_CODE_HIGH     8'hFF
`define RST_FAULT_CFG     4'h7

`define BIT_SOFT_RESET    0
`define BIT_CHIP_EN       0
`define BIT_SHORT_EN      3
`define BIT_SD_THERMAL    2
`define BIT_SD_CURRENT    1
`define BIT_SD_OVERVOLT   0

`define CLK_PERIOD_NS     50
`define RAMP_BASE_NS      125000
`define SMP_800K_NS       1250
`define SMP_4M_NS         250
`define FILT_100_NS       100
`define FILT_150_NS       150
`define FILT_200_NS       200
`define HYST_MAX          3'h6
`define DUTY_FULL         11'h7FF
`define RAMP_CNT_W        20

`endif

/* File: design/backlight_pkg.sv */
/*
 * Types of the backlight driver register bank: the single state record.
 * Assumes backlight_params.svh is on the include path.
 */
`include "backlight_params.svh"

package backlight_pkg;

	typedef struct packed {
		logic [5:0]             sync1;
		logic [5:0]             sync2;
		logic [3:0]             enable;
		logic [6:0]             bright_cfg;
		logic [7:0]             pwm_cfg;
		logic [6:0]             boost_cfg;
		logic [7:0]             af_upper;
		logic [7:0]             af_lower;
		logic [2:0]             code_low;
		logic [7:0]             code_high;
		logic [3:0]             fault_cfg;
		logic [4:0]             flags;
		logic                   shutdown;
		logic [7:0]             rdata;
		logic                   rd_valid;
		logic                   filt_level;
		logic [2:0]             filt_cnt;
		logic [4:0]             smp_cnt;
		logic [10:0]            win_cnt;
		logic [11:0]            hi_cnt;
		logic [10:0]            duty;
		logic [`RAMP_CNT_W-1:0] ramp_cnt;
		logic [10:0]            ramped;
		logic [10:0]            bright;
	} state_s;

	function automatic state_s default_state();
		state_s s;
		s            = '0;
		s.enable     = `RST_ENABLE;
		s.bright_cfg = `RST_BRIGHT_CFG;
		s.pwm_cfg    = `RST_PWM_CFG;
		s.boost_cfg  = `RST_BOOST_CFG;
		s.af_upper   = `RST_AF;
		s.af_lower   = `RST_AF;
		s.code_low   = `RST_CODE_LOW;
		s.code_high  = `RST_CODE_HIGH;
		s.fault_cfg  = `RST_FAULT_CFG;
		return s;
	endfunction

endpackage

/* File: design/backlight_regs.sv */
/*
 * Register bank and digital brightness path of a three-string backlight
 * driver: registers, soft reset, pwm input conditioning, ramp, auto frequency
 * selection, sticky fault flags and fault shutdown.
 * Assumes a byte-wide register port driven by an i2c target engine on the
 * same clock, and asynchronous pwm and fault level inputs from pins/analog.
 */
`timescale 1ns/1ps

`include "backlight_params.svh"

module backlight_regs
	import backlight_pkg::*;
#(
	parameter logic [3:0] REVISION_CODE    = 4'h1,  // arbitrary value
	parameter int         RAMP_BASE_CYCLES = `RAMP_BASE_NS / `CLK_PERIOD_NS
)
(
	// clock and reset
	input  wire logic        I_CLOCK,
	input  wire logic        I_RESETN,
	// register port from the i2c engine
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	output logic             o_rd_valid,
	// asynchronous inputs
	input  wire logic        i_pwm,
	input  wire logic        i_string_open,
	input  wire logic        i_string_short,
	input  wire logic        i_thermal_trip,
	input  wire logic        i_switch_current_limit,
	input  wire logic        i_overvoltage_limit,
	// controls to the analog section
	output logic             o_chip_enable,
	output logic      [2:0]  o_sink_enable,
	output logic             o_exp_mapping,
	output logic      [10:0] o_brightness,
	output logic             o_freq_no_shift,
	output logic             o_freq_1mhz,
	output logic             o_inductor_10uh,
	output logic      [1:0]  o_overvoltage_limit_sel,
	output logic      [1:0]  o_switch_current_limit_sel,
	output logic      [1:0]  o_auto_freq,
	output logic             o_short_detect_en
);

	localparam int SMP_800K = `SMP_800K_NS / `CLK_PERIOD_NS;
	localparam int SMP_4M   = `SMP_4M_NS / `CLK_PERIOD_NS;
	localparam int FILT_100 = (`FILT_100_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int FILT_150 = (`FILT_150_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int FILT_200 = (`FILT_200_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam state_s RESET_STATE = default_state();

	// elaboration-time refusal of step lengths the counter cannot hold
	if (RAMP_BASE_CYCLES < 1 || (RAMP_BASE_CYCLES << 7) >= (1 << `RAMP_CNT_W))
	begin
		$error("RAMP_BASE_CYCLES out of range");
	end

	state_s state;
	state_s next_state;

	// combinational helpers
	logic [10:0] code;
	logic [10:0] ramp_in;
	logic [21:0] prod_pre;
	logic [21:0] prod_post;
	logic [4:0]  smp_div;
	logic [2:0]  filt_need;
	logic        pwm_active;
	logic        smp_tick;
	logic [10:0] new_duty;
	logic [10:0] duty_diff;
	logic [2:0]  hyst;
	logic        ramp_tick;
	logic [`RAMP_CNT_W-1:0] ramp_limit;
	logic [4:0]  fault_evt;
	logic        sd_evt;
	logic        flag_read;
	logic [7:0]  rd_mux;
	logic [10:0] target;

	always_comb
	begin
		next_state = state;

		// two-flop synchronisers for pin and analog levels
		next_state.sync1 = {i_string_open, i_string_short, i_thermal_trip,
		                    i_switch_current_limit, i_overvoltage_limit, i_pwm};
		next_state.sync2 = state.sync1;

		// pulse filter: level must hold for the chosen time
		case (state.pwm_cfg[1:0])
			2'b00:   filt_need = 3'(0);
			2'b01:   filt_need = 3'(FILT_100);
			2'b10:   filt_need = 3'(FILT_150);
			default: filt_need = 3'(FILT_200);
		endcase
		if (state.sync2[0] == state.filt_level)
			next_state.filt_cnt = '0;
		else if (state.filt_cnt + 3'h1 >= filt_need)
		begin
			next_state.filt_level = state.sync2[0];
			next_state.filt_cnt   = '0;
		end
		else
			next_state.filt_cnt = state.filt_cnt + 3'h1;
		pwm_active = state.pwm_cfg[5] ? state.filt_level : ~state.filt_level;

		// sample rate divider; 24 MHz exceeds the core clock, so every cycle
		case (state.pwm_cfg[7:6])
			2'b00:   smp_div = 5'(SMP_800K);
			2'b01:   smp_div = 5'(SMP_4M);
			default: smp_div = 5'h01;
		endcase
		smp_tick = (state.smp_cnt == 5'h00);
		next_state.smp_cnt = smp_tick ? smp_div - 5'h01 : state.smp_cnt - 5'h01;

		// duty measured over a window of 2048 samples
		new_duty = state.hi_cnt[11] ? `DUTY_FULL : state.hi_cnt[10:0];
		duty_diff = (new_duty > state.duty) ? new_duty - state.duty
		                                    : state.duty - new_duty;
		hyst = (state.pwm_cfg[4:2] > `HYST_MAX) ? `HYST_MAX : state.pwm_cfg[4:2];
		if (smp_tick)
		begin
			next_state.win_cnt = state.win_cnt + 11'h001;
			next_state.hi_cnt  = state.hi_cnt + {11'h000, pwm_active};
			if (state.win_cnt == `DUTY_FULL)
			begin
				next_state.hi_cnt = {11'h000, pwm_active};
				if (duty_diff >= {8'h00, hyst})
					next_state.duty = new_duty;
			end
		end

		// brightness source selection and ramp
		code      = {state.code_high, state.code_low};
		prod_pre  = code * state.duty;
		prod_post = state.ramped * state.duty;
		case (state.bright_cfg[5:4])
			2'b00:   ramp_in = code;
			2'b01:   ramp_in = state.duty;
			2'b10:   ramp_in = prod_pre[21:11];
			default: ramp_in = code;
		endcase
		ramp_limit = `RAMP_CNT_W'(RAMP_BASE_CYCLES << state.bright_cfg[2:0]) - 1'b1;
		ramp_tick  = (state.ramp_cnt >= ramp_limit);
		next_state.ramp_cnt = ramp_tick ? '0 : state.ramp_cnt + 1'b1;
		if (!state.bright_cfg[3])
			next_state.ramped = ramp_in;
		else if (ramp_tick && state.ramped < ramp_in)
			next_state.ramped = state.ramped + 11'h001;
		else if (ramp_tick && state.ramped > ramp_in)
			next_state.ramped = state.ramped - 11'h001;
		target = (state.bright_cfg[5:4] == 2'b11) ? prod_post[21:11] : state.ramped;
		next_state.bright = target;

		// sticky fault flags, set wins over clear on read
		fault_evt = {state.sync2[5],
		             state.sync2[4] & state.fault_cfg[`BIT_SHORT_EN],
		             state.sync2[3:1]};
		flag_read = i_rd_en && (i_addr == `OFS_FAULT_STATUS);
		next_state.flags = (flag_read ? 5'h00 : state.flags) | fault_evt;

		sd_evt = (fault_evt[2] & ~state.fault_cfg[`BIT_SD_THERMAL]) |
		         (fault_evt[1] & ~state.fault_cfg[`BIT_SD_CURRENT]) |
		         ((fault_evt[0] | fault_evt[4]) & ~state.fault_cfg[`BIT_SD_OVERVOLT]);
		if (sd_evt)
			next_state.shutdown = 1'b1;
		else if (flag_read)
			next_state.shutdown = 1'b0;

		// read mux
		case (i_addr)
			`OFS_REVISION:     rd_mux = {4'h0, REVISION_CODE};
			`OFS_SOFT_RESET:   rd_mux = 8'h00;
			`OFS_ENABLE:       rd_mux = {4'h0, state.enable};
			`OFS_BRIGHT_CFG:   rd_mux = {state.bright_cfg, 1'b0};
			`OFS_PWM_CFG:      rd_mux = state.pwm_cfg;
			`OFS_BOOST_CFG:    rd_mux = {1'b0, state.boost_cfg};
			`OFS_AF_UPPER:     rd_mux = state.af_upper;
			`OFS_AF_LOWER:     rd_mux = state.af_lower;
			`OFS_CODE_LOW:     rd_mux = {5'h00, state.code_low};
			`OFS_CODE_HIGH:    rd_mux = state.code_high;
			`OFS_FAULT_CFG:    rd_mux = {4'h0, state.fault_cfg};
			`OFS_FAULT_STATUS: rd_mux = {3'h0, state.flags};
			default:           rd_mux = 8'h00;
		endcase
		next_state.rd_valid = i_rd_en;
		if (i_rd_en)
			next_state.rdata = rd_mux;

		// register writes
		if (i_wr_en)
		begin
			case (i_addr)
				`OFS_ENABLE:     next_state.enable = i_wdata[3:0];
				`OFS_BRIGHT_CFG: next_state.bright_cfg = i_wdata[7:1];
				`OFS_PWM_CFG:    next_state.pwm_cfg = i_wdata;
				`OFS_BOOST_CFG:  next_state.boost_cfg = i_wdata[6:0];
				`OFS_AF_UPPER:   next_state.af_upper = i_wdata;
				`OFS_AF_LOWER:   next_state.af_lower = i_wdata;
				`OFS_CODE_LOW:   next_state.code_low = i_wdata[2:0];
				`OFS_CODE_HIGH:  next_state.code_high = i_wdata;
				`OFS_FAULT_CFG:  next_state.fault_cfg = i_wdata[3:0];
				default:         next_state.enable = next_state.enable;
			endcase
		end

		// shutdown forces chip enable low and holds it there
		if (sd_evt || (state.shutdown && !flag_read))
			next_state.enable[`BIT_CHIP_EN] = 1'b0;

		// soft reset returns everything to defaults; bit never stores
		if (i_wr_en && i_addr == `OFS_SOFT_RESET && i_wdata[`BIT_SOFT_RESET])
			next_state = RESET_STATE;
	end

	always_ff @(posedge I_CLOCK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			state <= RESET_STATE;
		else
			state <= next_state;
	end

	// outputs to the i2c engine and the analog section
	assign o_rdata       = state.rdata;
	assign o_rd_valid    = state.rd_valid;
	assign o_chip_enable = state.enable[`BIT_CHIP_EN] & ~state.shutdown;
	assign o_sink_enable = state.enable[3:1] & {3{o_chip_enable}};
	assign o_exp_mapping = state.bright_cfg[6];
	assign o_brightness  = state.bright;
	assign o_freq_no_shift            = state.boost_cfg[6];
	assign o_freq_1mhz                = state.boost_cfg[5];
	assign o_inductor_10uh            = state.boost_cfg[4];
	assign o_overvoltage_limit_sel    = state.boost_cfg[3:2];
	assign o_switch_current_limit_sel = state.boost_cfg[1:0];
	assign o_short_detect_en          = state.fault_cfg[`BIT_SHORT_EN];

	// auto frequency: 2 = 1 MHz, 1 = 500 kHz, 0 = 250 kHz
	assign o_auto_freq = (state.bright[10:3] >= state.af_upper) ? 2'h2 :
	                     (state.bright[10:3] >= state.af_lower) ? 2'h1 :
	                     2'h0;

endmodule

/* File: verification/backlight_regs_chk.sv */
/*
 * Assertions on the register port and the config outputs of backlight_regs.
 * Assumes it is bound to backlight_regs and sees only its ports.
 */
`timescale 1ns/1ps

module backlight_regs_chk
	import backlight_pkg::*;
#(
	parameter logic [3:0] REVISION_CODE    = 4'h1,
	parameter int         RAMP_BASE_CYCLES = 2
)
(
	// clock and reset
	input  wire logic       I_CLOCK,
	input  wire logic       I_RESETN,
	// register port
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic [7:0] o_rdata,
	// controls
	input  wire logic       o_chip_enable,
	input  wire logic [2:0] o_sink_enable,
	input  wire logic       o_exp_mapping,
	input  wire logic       o_freq_no_shift,
	input  wire logic       o_freq_1mhz,
	input  wire logic       o_inductor_10uh,
	input  wire logic [1:0] o_overvoltage_limit_sel,
	input  wire logic [1:0] o_switch_current_limit_sel,
	input  wire logic       o_short_detect_en
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESETN);

	logic known;
	assign known = i_addr inside {8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h16,
		8'h18, 8'h19, 8'h1E, 8'h1F};

	property p_rev; i_rd_en && i_addr == 8'h00 |=> o_rdata == {4'h0, REVISION_CODE}; endproperty
	a_rev: assert property (p_rev) else $error("revision readback wrong");
	property p_srst_rd; i_rd_en && i_addr == 8'h01 |=> o_rdata == 8'h00; endproperty
	a_srst_rd: assert property (p_srst_rd) else $error("soft reset reads nonzero");
	property p_undef; i_rd_en && !known |=> o_rdata == 8'h00; endproperty
	a_undef: assert property (p_undef) else $error("undefined offset reads nonzero");
	property p_low; i_rd_en && i_addr == 8'h18 |=> o_rdata[7:3] == 5'h00; endproperty
	a_low: assert property (p_low) else $error("code low upper bits set");
	property p_flag; i_rd_en && i_addr == 8'h1F |=> o_rdata[7:5] == 3'h0; endproperty
	a_flag: assert property (p_flag) else $error("flag reserved bits set");
	property p_map; i_wr_en && i_addr == 8'h11 |=> o_exp_mapping == $past(i_wdata[7]); endproperty
	a_map: assert property (p_map) else $error("mapping bit not applied");
	property p_short;
		i_wr_en && i_addr == 8'h1E |=> o_short_detect_en == $past(i_wdata[3]);
	endproperty
	a_short: assert property (p_short) else $error("short detect bit not applied");
	property p_sink;
		i_wr_en && i_addr == 8'h10 |=> o_sink_enable == ($past(i_wdata[3:1]) & {3{o_chip_enable}});
	endproperty
	a_sink: assert property (p_sink) else $error("sink enables not applied");
	property p_boost;
		i_wr_en && i_addr == 8'h13 |=> {o_freq_no_shift, o_freq_1mhz, o_inductor_10uh,
			o_overvoltage_limit_sel, o_switch_current_limit_sel} == $past(i_wdata[6:0]);
	endproperty
	a_boost: assert property (p_boost) else $error("boost fields not applied");
	property p_soft;
		i_wr_en && i_addr == 8'h01 && i_wdata[0] |=> o_freq_1mhz && !o_exp_mapping
			&& o_overvoltage_limit_sel == 2'h3 && !o_short_detect_en;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset left settings");

	c_flag: cover property (i_rd_en && i_addr == 8'h1F);
	c_soft: cover property (i_wr_en && i_addr == 8'h01 && i_wdata[0]);
	c_off: cover property ($fell(o_chip_enable));
endmodule

bind backlight_regs backlight_regs_chk #(
	.REVISION_CODE(REVISION_CODE),
	.RAMP_BASE_CYCLES(RAMP_BASE_CYCLES)
) u_chk (.I_CLOCK, .I_RESETN, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata,
	.o_chip_enable, .o_sink_enable, .o_exp_mapping, .o_freq_no_shift, .o_freq_1mhz,
	.o_inductor_10uh, .o_overvoltage_limit_sel, .o_switch_current_limit_sel,
	.o_short_detect_en);

/* File: verification/reg_host.sv */
/*
 * Register-port host: one-cycle write and read strobes.
 * Assumes the bank samples strobes on the rising clock edge.
 */
`timescale 1ns/1ps

module reg_host
(
	// clock
	input  wire logic       i_clk,
	// strobes to the bank
	output logic            o_wr = 1'b0,
	output logic            o_rd = 1'b0,
	output logic      [7:0] o_addr = 8'h00,
	output logic      [7:0] o_data = 8'h00
);
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr   <= w;
		o_rd   <= !w;
		o_addr <= a;
		o_data <= d;
		@(posedge i_clk);
		o_wr   <= 1'b0;
		o_rd   <= 1'b0;
		// released lines do not keep the last value
		o_addr <= ~a;
		o_data <= ~d;
	endtask
endmodule

/* File: verification/testbench.sv */
/*
 * Self-checking bench of backlight_regs: reads queue expectations, a monitor
 * compares them. Assumes reg_host and the bound checker are compiled.
 */
`timescale 1ns/1ps

`define CHK_EQ(got, exp) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end

module testbench;
	localparam logic [3:0] REV = 4'hA;  // arbitrary value
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        pwm = 1'b0;
	logic [4:0]  flt = 5'h00;
	logic        wr_en, rd_en, rd_valid, chip_en;
	logic [7:0]  addr, wdata, rdata, want, v;
	logic [2:0]  sink;
	logic [10:0] bright;
	logic [1:0]  afreq;
	logic [7:0]  exp_q[$];
	int          n_fail = 0;
	int          num_checks = 0;
	int          cyc = 0;
	logic [7:0]  ofs[12] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h18,
		8'h19, 8'h1E, 8'h1F};
	logic [7:0]  dflt[12] = '{{4'h0, REV}, 8'h00, 8'h0F, 8'h60, 8'hF3, 8'h6F, 8'h00, 8'h00,
		8'h07, 8'hFF, 8'h07, 8'h00};
	logic [7:0]  msk[12] = '{8'h00, 8'h00, 8'h0F, 8'hFE, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h07,
		8'hFF, 8'h0F, 8'h00};

	always #25 clk = ~clk;

	reg_host u_host (.i_clk(clk), .o_wr(wr_en), .o_rd(rd_en), .o_addr(addr), .o_data(wdata));

	backlight_regs #(.REVISION_CODE(REV), .RAMP_BASE_CYCLES(4)) u_dut (
		.I_CLOCK(clk), .I_RESETN(rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
		.i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid), .i_pwm(pwm),
		.i_string_open(flt[4]), .i_string_short(flt[3]), .i_thermal_trip(flt[2]),
		.i_switch_current_limit(flt[1]), .i_overvoltage_limit(flt[0]),
		.o_chip_enable(chip_en), .o_sink_enable(sink), .o_exp_mapping(), .o_brightness(bright),
		.o_freq_no_shift(), .o_freq_1mhz(), .o_inductor_10uh(), .o_overvoltage_limit_sel(),
		.o_switch_current_limit_sel(), .o_auto_freq(afreq), .o_short_detect_en());

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.xfer(1'b0, a, 8'h00);
	endtask

	task automatic defaults();
		for (int i = 0; i < 12; i++)
			rd(ofs[i], dflt[i]);
		rd(8'h14, 8'h00);
	endtask

	task automatic pulse(input logic [4:0] p);
		@(posedge clk) flt <= p;
		repeat (4) @(posedge clk);
		flt <= 5'h00;
		repeat (4) @(posedge clk);
	endtask

	task automatic af(input logic [7:0] u, input logic [7:0] l, input logic [1:0] e);
		wr(8'h15, u);
		wr(8'h16, l);
		repeat (4) @(posedge clk);
		`CHK_EQ(afreq, e)
	endtask

	task automatic complete_run();
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk)
		if (rd_valid === 1'b1)
		begin
			want = exp_q.pop_front();
			`CHK_EQ(rdata, want)
		end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			complete_run();
		end
	end

	initial
	begin
		void'($urandom(32'h7b10));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		defaults();
		wr(8'h10, 8'h01);
		for (int n = 0; n < 24; n++)
		begin
			v = 8'($urandom);
			if (ofs[n % 12] == 8'h10)
				v = (v & 8'hF0) | 8'h01;
			wr(ofs[n % 12], v);
			rd(ofs[n % 12], (v & msk[n % 12]) | (dflt[n % 12] & ~msk[n % 12]));
			wr(8'h14, ~v);
		end
		wr(8'h01, 8'hFF);
		defaults();
		wr(8'h1E, 8'h0F);
		pulse(5'h1F);
		rd(8'h1F, 8'h1F);
		rd(8'h1F, 8'h00);
		@(posedge clk) flt <= 5'h01;
		repeat (5) @(posedge clk);
		rd(8'h1F, 8'h01);
		rd(8'h1F, 8'h01);
		pulse(5'h00);
		rd(8'h1F, 8'h01);
		rd(8'h1F, 8'h00);
		wr(8'h1E, 8'h07);
		pulse(5'h08);
		rd(8'h1F, 8'h00);
		for (int k = 0; k < 3; k++)
		begin
			wr(8'h1E, 8'h08 | (8'h07 & ~(8'h01 << k)));
			pulse(5'(5'h01 << k));
			`CHK_EQ({chip_en, sink}, 4'h0)
			wr(8'h10, 8'h0F);
			rd(8'h10, 8'h0E);
			rd(8'h1F, 8'h01 << k);
			wr(8'h10, 8'h0F);
			rd(8'h10, 8'h0F);
			`CHK_EQ({chip_en, sink}, 4'hF)
		end
		wr(8'h10, 8'h01);
		wr(8'h11, 8'h00);
		wr(8'h18, 8'h05);
		wr(8'h19, 8'h80);
		repeat (8) @(posedge clk);
		`CHK_EQ(bright, 11'h405)
		af(8'h90, 8'h40, 2'h1);
		af(8'h80, 8'h40, 2'h2);
		af(8'h90, 8'h81, 2'h0);
		wr(8'h11, 8'h20);
		pwm <= 1'b1;
		repeat (4200) @(posedge clk);
		`CHK_EQ(bright, 11'h7FF)
		wr(8'h12, 8'hD3);
		pwm <= 1'b0;
		repeat (4200) @(posedge clk);
		`CHK_EQ(bright, 11'h7FF)
		pwm <= 1'b1;
		repeat (4200) @(posedge clk);
		`CHK_EQ(bright, 11'h000)
		wr(8'h11, 8'h40);
		pwm <= 1'b0;
		repeat (4200) @(posedge clk);
		`CHK_EQ(bright, 11'h404)
		wr(8'h11, 8'h60);
		repeat (8) @(posedge clk);
		`CHK_EQ(bright, 11'h404)
		wr(8'h11, 8'h70);
		wr(8'h19, 8'h81);
		repeat (8) @(posedge clk);
		`CHK_EQ(bright == 11'h40C, 1'b0)
		repeat (60) @(posedge clk);
		`CHK_EQ(bright, 11'h40C)
		repeat (4) @(posedge clk);
		`CHK_EQ(exp_q.size() == 0, 1'b1)
		complete_run();
	end
endmodule
